// ===== tb/mga_mic_front_model.sv
// behavioural microphone front end raising queue level events
`timescale 1ns/1ps
module mga_mic_front_model
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // level requests from the bench, one per level flag
    input wire [3:0] level_req,
    // level events towards the register bank, bit order as the flags
    output reg [3:0] level_evt
);
    // events follow requests one cycle late, like a real fill counter;
    // a held request gives a level, not a pulse, so clears can collide
    always @(posedge aclk)
    begin
        if (!aresetn)
            level_evt <= 4'h0;
        else
            level_evt <= level_req;
    end
endmodule // mga_mic_front_model

// ===== tb/mga_mic_gain_regs_assertions.sv
// checker for the mic gain register bank, bound to its ports
`timescale 1ns/1ps
`include "mga_defs.vh"
module mga_mic_gain_regs_chk
(
    // clock and reset
    input wire aclk,
    input wire aresetn,
    // bus handshakes and answers
    input wire s_axi_awready,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // level events
    input wire first_audio_queue_low_evt,
    input wire first_audio_queue_high_evt,
    input wire second_audio_queue_high_evt,
    input wire third_audio_queue_high_evt,
    // front end controls and interrupt
    input wire [5:0] mic_gain_code,
    input wire signed [`MGA_GAIN_W-1:0] mic_gain_half_db,
    input wire stereo_capture,
    input wire digital_microphone_sel,
    input wire [3:0] queue_capture_en,
    input wire irq
);
    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    reg [2:0] live_r; // cycles since reset, saturates at seven
    wire [2:0] live_nxt;
    wire any_evt;
    assign live_nxt = (live_r == 3'h7) ? live_r : live_r + 3'h1;
    assign any_evt = first_audio_queue_low_evt | first_audio_queue_high_evt
        | second_audio_queue_high_evt | third_audio_queue_high_evt;
    // derived outputs lag reset by one edge, so checks wait for settling
    always @(posedge aclk)
    begin
        if (!aresetn)
            live_r <= 3'h0;
        else
            live_r <= live_nxt;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_gain_law:
        assert property (live_r == 3'h7 |-> mic_gain_half_db ==
            8'(({2'b00, mic_gain_code} - 8'h20) * 8'h03))
        else $error("gain value does not follow gain code");
    a_reset_values:
        assert property ($rose(aresetn) |-> ##2 (mic_gain_code == 6'h20
            && !stereo_capture && !digital_microphone_sel
            && queue_capture_en == 4'h9))
        else $error("front end controls wrong after reset");
    a_ctrl_cause:
        assert property (live_r == 3'h7 && ($changed(mic_gain_code)
            || $changed(stereo_capture) || $changed(digital_microphone_sel))
            |-> $past(s_axi_bvalid))
        else $error("front end control moved without a write");
    a_irq_fall:
        assert property (live_r != 3'h0 && $fell(irq) |-> $past(s_axi_bvalid))
        else $error("interrupt dropped without a write");
    a_irq_rise:
        assert property ($rose(irq) |-> $past(any_evt, 2)
            || $past(s_axi_bvalid))
        else $error("interrupt rose without cause");
    a_b_hold:
        assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    a_r_hold:
        assert property (s_axi_rvalid && !s_axi_rready
            |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_w_block:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_r_block:
        assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    c_irq: cover property ($rose(irq));
    c_err: cover property (s_axi_bvalid && s_axi_bresp == 2'b10);
    c_stereo: cover property ($rose(stereo_capture));
endmodule // mga_mic_gain_regs_chk

bind mga_mic_gain_regs mga_mic_gain_regs_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .first_audio_queue_low_evt(first_audio_queue_low_evt),
    .first_audio_queue_high_evt(first_audio_queue_high_evt),
    .second_audio_queue_high_evt(second_audio_queue_high_evt),
    .third_audio_queue_high_evt(third_audio_queue_high_evt),
    .mic_gain_code(mic_gain_code), .mic_gain_half_db(mic_gain_half_db),
    .stereo_capture(stereo_capture),
    .digital_microphone_sel(digital_microphone_sel),
    .queue_capture_en(queue_capture_en), .irq(irq));

// ===== tb/tb_top.sv
// self-checking bench for the mic gain register bank
`timescale 1ns/1ps
`include "mga_defs.vh"
module tb_top;
    // byte addresses are four times the register index
    localparam [15:0] A_EN = {2'b00, `MGA_IDX_QUEUE_ENABLE, 2'b00};
    localparam [15:0] A_CTL = {2'b00, `MGA_IDX_MIC_CONTROL, 2'b00};
    localparam [15:0] A_FLG = {2'b00, `MGA_IDX_IRQ_FLAGS, 2'b00};
    localparam [15:0] A_BAD = 16'h2c44; // hole between enable and control
    reg aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    reg s_axi_arvalid, s_axi_rready;
    reg [15:0] s_axi_awaddr, s_axi_araddr;
    reg [31:0] s_axi_wdata, rd;
    reg [3:0] level_req; // bench asks the front end for level events
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, stereo_capture, digital_microphone_sel, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [3:0] evt, queue_capture_en;
    wire [5:0] mic_gain_code;
    wire signed [7:0] mic_gain_half_db;
    integer failures, total_checks, i;
    reg [15:0] rows [0:7]; // control byte, expected half-dB gain
    mga_mic_gain_regs #(.ADDR_W(16)) DUT (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .first_audio_queue_low_evt(evt[0]),
        .first_audio_queue_high_evt(evt[1]),
        .second_audio_queue_high_evt(evt[2]),
        .third_audio_queue_high_evt(evt[3]), .mic_gain_code(mic_gain_code),
        .mic_gain_half_db(mic_gain_half_db), .stereo_capture(stereo_capture),
        .digital_microphone_sel(digital_microphone_sel),
        .queue_capture_en(queue_capture_en), .irq(irq));
    mga_mic_front_model u_front (.aclk(aclk), .aresetn(aresetn),
        .level_req(level_req), .level_evt(evt));
    // free running 125 MHz clock
    initial
    begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    // watchdog: whole run needs well under 3000 cycles
    initial
    begin
        repeat (6000) @(posedge aclk);
        failures = failures + 1;
        wrap_up;
    end
    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
        total_checks = total_checks + 1;
        if (g !== e)
        begin
            failures = failures + 1;
            $display("MISMATCH %0s expected %h seen %h", nm, e, g);
        end
    end
    endtask
    // one write; bready is raised only once bvalid shows, to stall it
    task axi_wr(input [15:0] a, input [31:0] d, input [1:0] er);
        integer n;
        reg done;
    begin
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 60 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready)
            begin
                done = 1'b1;
                s_axi_bready <= 1'b0;
                chk("bresp", er, s_axi_bresp);
            end
            else if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end
        if (!done) chk("bdone", 1, 0);
    end
    endtask
    // one read, compared with the expected word and answer
    task axi_rd(input [15:0] a, input [31:0] ed, input [1:0] er);
        integer n;
        reg done;
    begin
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        done = 1'b0;
        for (n = 0; n < 60 && !done; n = n + 1)
        begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready)
            begin
                done = 1'b1;
                s_axi_rready <= 1'b0;
                chk("rresp", er, s_axi_rresp);
                chk("rdata", ed, s_axi_rdata);
            end
            else if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end
        if (!done) chk("rdone", 1, 0);
    end
    endtask
    // one-cycle level event on queue k, then time for irq to follow
    task pulse(input integer k);
    begin
        @(posedge aclk);
        level_req[k] <= 1'b1;
        @(posedge aclk);
        level_req[k] <= 1'b0;
        repeat (4) @(posedge aclk);
        #1;
    end
    endtask
    task wrap_up;
    begin
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready, level_req} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        failures = 0;
        total_checks = 0;
        aresetn = 1'b0;
        rows[0] = 16'h00a0; rows[1] = 16'h1cf4; rows[2] = 16'h2000;
        rows[3] = 16'h240c; rows[4] = 16'h3848; rows[5] = 16'h3c54;
        rows[6] = 16'h7c54; rows[7] = 16'hbf5d;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(A_EN, 32'hf9, 2'b00);
        axi_rd(A_CTL, 32'h20, 2'b00);
        axi_rd(A_FLG, 32'h0, 2'b00);
        chk("capt_en", 32'h9, {28'h0, queue_capture_en});
        $display("test reset values done");
        // gain law, capture format and source per table row
        for (i = 0; i < 8; i = i + 1)
        begin
            axi_wr(A_CTL, {24'h0, rows[i][15:8]}, 2'b00);
            @(posedge aclk);
            #1;
            chk("halfdb", rows[i][7:0], {24'h0, mic_gain_half_db});
            chk("code", rows[i][13:8], {26'h0, mic_gain_code});
            chk("stereo", rows[i][14], {31'h0, stereo_capture});
            chk("digital", rows[i][15], {31'h0, digital_microphone_sel});
            axi_rd(A_CTL, {24'h0, rows[i][15:8]}, 2'b00);
        end
        $display("test gain table done");
        // each flag: set, survives a zero write, cleared by a one
        for (i = 0; i < 4; i = i + 1)
        begin
            pulse(i);
            chk("irq", 1, {31'h0, irq});
            axi_wr(A_FLG, 32'h0, 2'b00);
            axi_rd(A_FLG, 32'h1 << i, 2'b00);
            axi_wr(A_FLG, 32'h1 << i, 2'b00);
            repeat (2) @(posedge aclk);
            #1;
            chk("irq", 0, {31'h0, irq});
            axi_rd(A_FLG, 32'h0, 2'b00);
        end
        $display("test flags done");
        // masked low event sets its flag but raises no interrupt
        axi_wr(A_EN, 32'he6, 2'b00);
        pulse(0);
        chk("irq", 0, {31'h0, irq});
        chk("capt_en", 32'h6, {28'h0, queue_capture_en});
        axi_rd(A_FLG, 32'h1, 2'b00);
        axi_wr(A_EN, 32'hf9, 2'b00);
        repeat (2) @(posedge aclk);
        #1;
        chk("irq", 1, {31'h0, irq});
        axi_wr(A_FLG, 32'h1, 2'b00);
        $display("test mask done");
        // flag set, then an event in the very clear cycle: event wins
        pulse(1);
        fork
            axi_wr(A_FLG, 32'h2, 2'b00);
            pulse(1);
        join
        repeat (3) @(posedge aclk);
        axi_rd(A_FLG, 32'h2, 2'b00);
        axi_wr(A_FLG, 32'h2, 2'b00);
        axi_rd(A_FLG, 32'h0, 2'b00);
        $display("test collision done");
        // unmapped place, then a mid-run reset
        axi_wr(A_BAD, 32'hff, 2'b10);
        axi_rd(A_BAD, 32'h0, 2'b10);
        axi_rd(A_CTL, 32'hbf, 2'b00);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        axi_rd(A_CTL, 32'h20, 2'b00);
        $display("test unmapped and reset done");
        wrap_up;
    end
endmodule // tb_top

// ===== verilog/mga_defs.vh
// register indices, field positions and reset values of the mic gain block
`ifndef MGA_DEFS_VH
`define MGA_DEFS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define MGA_IDX_W 12
`define MGA_IDX_QUEUE_ENABLE 12'hb10
`define MGA_IDX_MIC_CONTROL 12'hb12
`define MGA_IDX_IRQ_FLAGS 12'hb13

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MGA_RST_QUEUE_ENABLE 8'hf9
`define MGA_RST_MIC_CONTROL 8'h20
`define MGA_RST_IRQ_FLAGS 4'h0

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MGA_GAIN_HI 5
`define MGA_GAIN_LO 0
`define MGA_STEREO_BIT 6
`define MGA_DIGITAL_BIT 7
`define MGA_CAPT_EN_HI 3
`define MGA_CAPT_EN_LO 0
`define MGA_IRQ_EN_HI 7
`define MGA_IRQ_EN_LO 4
`define MGA_FLAG_FIRST_LOW 0
`define MGA_FLAG_FIRST_HIGH 1
`define MGA_FLAG_SECOND_HIGH 2
`define MGA_FLAG_THIRD_HIGH 3
`define MGA_NUM_FLAGS 4

// ----------------------------------------------------------------------
// gain law: half-dB units, zero dB code, three half-dB per code step
// ----------------------------------------------------------------------
`define MGA_GAIN_ZERO_CODE 8'h20
`define MGA_GAIN_W 8

// ----------------------------------------------------------------------
// bus answers
// ----------------------------------------------------------------------
`define MGA_RESP_OKAY 2'b00
`define MGA_RESP_SLVERR 2'b10
`define MGA_DATA_W 32
`define MGA_BYTE_W 8

`endif

// ===== verilog/mga_gain_map.v
// gain code to signed half-dB value converter
`timescale 1ns/1ps
`include "mga_defs.vh"

module mga_gain_map
(
    // gain code from the control register
    input wire [5:0] gain_code,
    // signed gain in half-dB steps, code 0x20 is zero
    output wire signed [`MGA_GAIN_W-1:0] gain_half_db
);

    // offset from the zero dB code, two's complement
    wire [`MGA_GAIN_W-1:0] code_off;
    // three times the offset, one code step is 1.5 dB
    wire [`MGA_GAIN_W-1:0] times_three;

    // ----------------------------------------------------------------------
    // linear law: four codes make 6 dB, so one code is three half-dB
    // ----------------------------------------------------------------------
    assign code_off = {2'b00, gain_code} - `MGA_GAIN_ZERO_CODE;
    // range -96..93 fits in eight bits, so the cut loses nothing
    assign times_three = code_off + {code_off[`MGA_GAIN_W-2:0], 1'b0};
    assign gain_half_db = times_three;

endmodule // mga_gain_map

// ===== verilog/mga_mic_gain_regs.v
// axi4-lite register bank for mic gain, capture mode and queue level flags
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mga_defs.vh"

// Notes on behaviour
// - code 0x20 is 0 dB, four codes 6 dB
// - code 0x3c gives +42 dB, 0x38 +36 dB
// - gain code in bits 5:0, 0x00 is -48 dB
// - bit 6: zero mono, one stereo capture
// - bit 7: zero analog, one digital microphone
// - flag bit 0 first queue low, write-one clears
// - flag bit 1 first queue high, write-one clears
// - flag bit 2 second queue high, write-one clears
// - flag bit 3 third queue high, write-one clears
// - low event interrupts only when enable bit 4 set
module mga_mic_gain_regs
#(
    parameter ADDR_W = 16
)
(
    // clock and reset
    input wire aclk,
    input wire aresetn,

    // axi4-lite write address channel
    input wire [ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,

    // axi4-lite write data channel
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,

    // axi4-lite write response channel
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,

    // axi4-lite read address channel
    input wire [ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,

    // axi4-lite read data channel
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,

    // level events from the audio queues, same clock domain
    input wire first_audio_queue_low_evt,
    input wire first_audio_queue_high_evt,
    input wire second_audio_queue_high_evt,
    input wire third_audio_queue_high_evt,

    // microphone front end controls
    output reg [5:0] mic_gain_code,
    output reg signed [`MGA_GAIN_W-1:0] mic_gain_half_db,
    output reg stereo_capture,
    output reg digital_microphone_sel,
    output reg [3:0] queue_capture_en,

    // interrupt request, level
    output reg irq
);

    // ----------------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------------
    // queue enable register: capture enables low, interrupt enables high
    reg [7:0] queue_enable_r;
    reg [7:0] queue_enable_nxt;

    // mic control: gain, mono or stereo, analog or digital
    reg [7:0] mic_control_r;
    reg [7:0] mic_control_nxt;

    // sticky level flags
    reg [`MGA_NUM_FLAGS-1:0] irq_flags_r;
    reg [`MGA_NUM_FLAGS-1:0] irq_flags_nxt;

    // ----------------------------------------------------------------------
    // bus channel state
    // ----------------------------------------------------------------------
    // write address captured and waiting for its data
    reg aw_have_r;
    reg aw_have_nxt;
    reg [ADDR_W-1:0] awaddr_r;
    reg [ADDR_W-1:0] awaddr_nxt;

    // write data captured and waiting for its address
    reg w_have_r;
    reg w_have_nxt;
    reg [31:0] wdata_r;
    reg [31:0] wdata_nxt;
    reg [3:0] wstrb_r;
    reg [3:0] wstrb_nxt;

    // response and read channel next values
    reg bvalid_nxt;
    reg [1:0] bresp_nxt;
    reg rvalid_nxt;
    reg [1:0] rresp_nxt;
    reg [31:0] rdata_nxt;
    reg awready_nxt;
    reg wready_nxt;
    reg arready_nxt;

    // ----------------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------------
    // both halves of a write are here and no response is pending
    wire do_write;

    // index of the captured write and of the incoming read
    wire [`MGA_IDX_W-1:0] wr_idx;
    wire [`MGA_IDX_W-1:0] rd_idx;

    // low byte lane enabled; registers are at most eight bits wide, the flag register four
    wire wr_lane0;

    // per-register write hits
    wire wr_enable_hit;
    wire wr_control_hit;
    wire wr_flags_hit;

    // incoming level events packed in flag order
    wire [`MGA_NUM_FLAGS-1:0] level_evt;

    // write-one-to-clear mask of this cycle
    wire [`MGA_NUM_FLAGS-1:0] flag_clear;

    // gain value from the converter
    wire signed [`MGA_GAIN_W-1:0] gain_half_db_w;

    // a write commits only while its response slot is free
    assign do_write = aw_have_r && w_have_r && !s_axi_bvalid;
    // only index bits decode; higher address bits alias
    assign wr_idx = awaddr_r[`MGA_IDX_W+1:2];
    assign rd_idx = s_axi_araddr[`MGA_IDX_W+1:2];
    assign wr_lane0 = wstrb_r[0];
    assign wr_enable_hit = do_write && (wr_idx == `MGA_IDX_QUEUE_ENABLE);
    assign wr_control_hit = do_write && (wr_idx == `MGA_IDX_MIC_CONTROL);
    assign wr_flags_hit = do_write && (wr_idx == `MGA_IDX_IRQ_FLAGS);

    // events come from logic on this clock, so no synchroniser
    assign level_evt[`MGA_FLAG_FIRST_LOW] = first_audio_queue_low_evt;
    assign level_evt[`MGA_FLAG_FIRST_HIGH] = first_audio_queue_high_evt;
    assign level_evt[`MGA_FLAG_SECOND_HIGH] = second_audio_queue_high_evt;
    assign level_evt[`MGA_FLAG_THIRD_HIGH] = third_audio_queue_high_evt;

    // only ones written in the low lane clear; zeros leave flags alone
    assign flag_clear = (wr_flags_hit && wr_lane0) ?
        wdata_r[`MGA_NUM_FLAGS-1:0] : {`MGA_NUM_FLAGS{1'b0}};

    // ----------------------------------------------------------------------
    // gain law converter
    // ----------------------------------------------------------------------
    mga_gain_map u_gain_map
    (
        .gain_code(mic_control_r[`MGA_GAIN_HI:`MGA_GAIN_LO]),
        .gain_half_db(gain_half_db_w)
    );

    // ----------------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------------
    // writes act only on the low byte; upper lanes are ignored
    always @*
    begin
        queue_enable_nxt = queue_enable_r;
        mic_control_nxt = mic_control_r;
        if (wr_enable_hit && wr_lane0)
        begin
            queue_enable_nxt = wdata_r[7:0];
        end
        if (wr_control_hit && wr_lane0)
        begin
            mic_control_nxt = wdata_r[7:0];
        end
        // set after clear, so an event in the clear cycle wins
        irq_flags_nxt = (irq_flags_r & ~flag_clear) | level_evt;
    end

    // ----------------------------------------------------------------------
    // bus channel next values
    // ----------------------------------------------------------------------
    // address and data are taken in either order, then one response
    always @*
    begin
        // everything holds unless a handshake moves it
        aw_have_nxt = aw_have_r;
        awaddr_nxt = awaddr_r;
        w_have_nxt = w_have_r;
        wdata_nxt = wdata_r;
        wstrb_nxt = wstrb_r;
        bvalid_nxt = s_axi_bvalid;
        bresp_nxt = s_axi_bresp;
        rvalid_nxt = s_axi_rvalid;
        rresp_nxt = s_axi_rresp;
        rdata_nxt = s_axi_rdata;
        // write address handshake
        if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_nxt = 1'b1;
            awaddr_nxt = s_axi_awaddr;
        end
        // write data handshake
        if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_nxt = 1'b1;
            wdata_nxt = s_axi_wdata;
            wstrb_nxt = s_axi_wstrb;
        end
        // both halves here: commit and answer
        if (do_write)
        begin
            aw_have_nxt = 1'b0;
            w_have_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            if (wr_enable_hit || wr_control_hit || wr_flags_hit)
            begin
                bresp_nxt = `MGA_RESP_OKAY;
            end
            else
            begin
                // unmapped address: nothing stored
                bresp_nxt = `MGA_RESP_SLVERR;
            end
        end
        else if (s_axi_bvalid && s_axi_bready)
        begin
            bvalid_nxt = 1'b0;
        end
        // read: answer one cycle after the address is taken
        if (s_axi_arvalid && s_axi_arready)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `MGA_RESP_OKAY;
            case (rd_idx)
                `MGA_IDX_QUEUE_ENABLE:
                begin
                    rdata_nxt = {24'h000000, queue_enable_r};
                end
                `MGA_IDX_MIC_CONTROL:
                begin
                    rdata_nxt = {24'h000000, mic_control_r};
                end
                `MGA_IDX_IRQ_FLAGS:
                begin
                    // upper bits of the flag register read as zero
                    rdata_nxt = {28'h0000000, irq_flags_r};
                end
                default:
                begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = `MGA_RESP_SLVERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            rvalid_nxt = 1'b0;
        end
        // readies are registered, so they look one step ahead
        awready_nxt = !aw_have_nxt && !bvalid_nxt;
        wready_nxt = !w_have_nxt && !bvalid_nxt;
        arready_nxt = !rvalid_nxt;
    end

    // ----------------------------------------------------------------------
    // flip-flops
    // ----------------------------------------------------------------------
    // synchronous active-low reset; every output comes from here
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            queue_enable_r <= `MGA_RST_QUEUE_ENABLE;
            mic_control_r <= `MGA_RST_MIC_CONTROL;
            irq_flags_r <= `MGA_RST_IRQ_FLAGS;
            aw_have_r <= 1'b0;
            awaddr_r <= {ADDR_W{1'b0}};
            w_have_r <= 1'b0;
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MGA_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= `MGA_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            // gain outputs show zero in reset, not the derived value
            mic_gain_code <= 6'h00;
            mic_gain_half_db <= 8'h00;
            stereo_capture <= 1'b0;
            digital_microphone_sel <= 1'b0;
            queue_capture_en <= 4'h0;
            irq <= 1'b0;
        end
        else
        begin
            queue_enable_r <= queue_enable_nxt;
            mic_control_r <= mic_control_nxt;
            irq_flags_r <= irq_flags_nxt;
            aw_have_r <= aw_have_nxt;
            awaddr_r <= awaddr_nxt;
            w_have_r <= w_have_nxt;
            wdata_r <= wdata_nxt;
            wstrb_r <= wstrb_nxt;
            s_axi_awready <= awready_nxt;
            s_axi_wready <= wready_nxt;
            s_axi_bvalid <= bvalid_nxt;
            s_axi_bresp <= bresp_nxt;
            s_axi_arready <= arready_nxt;
            s_axi_rvalid <= rvalid_nxt;
            s_axi_rresp <= rresp_nxt;
            s_axi_rdata <= rdata_nxt;
            // front end controls follow the stored register one cycle on
            mic_gain_code <= mic_control_r[`MGA_GAIN_HI:`MGA_GAIN_LO];
            mic_gain_half_db <= gain_half_db_w;
            stereo_capture <= mic_control_r[`MGA_STEREO_BIT];
            digital_microphone_sel <= mic_control_r[`MGA_DIGITAL_BIT];
            // capture enables copy the low half, registered one cycle on
            queue_capture_en <=
                queue_enable_r[`MGA_CAPT_EN_HI:`MGA_CAPT_EN_LO];
            // a flag interrupts only while its enable is set
            irq <= |(irq_flags_r &
                queue_enable_r[`MGA_IRQ_EN_HI:`MGA_IRQ_EN_LO]);
        end
    end

    // protection bits carry no meaning for this bank
    wire unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot, s_axi_wdata[31:8]};

endmodule // mga_mic_gain_regs
